/* File: design/fifo_handshake_pkg.sv */
// Constants, register map and state types of the handshake FIFO port
package fifo_handshake_pkg;
   localparam int          DEPTH     = 128;
   localparam logic [7:0]  DEPTH_CNT = 8'h80;
   localparam logic [6:0]  PTR_ONE   = 7'h01;
   localparam logic [7:0]  CNT_ONE   = 8'h01;
   localparam logic [7:0]  ZERO_BYTE = 8'h00;

   typedef logic [7:0] byte_t;
   typedef logic [2:0] addr_t;

   // Register indices
   localparam addr_t REG_DATA   = 3'h0;
   localparam addr_t REG_CTL    = 3'h1;
   localparam addr_t REG_FLAG   = 3'h2;
   localparam addr_t REG_STATUS = 3'h3;
   localparam addr_t REG_COUNT  = 3'h4;
   localparam addr_t REG_MSG    = 3'h5;

   // Control fields
   localparam int CTL_CLEAR_N   = 0;
   localparam int CTL_THREE     = 1;
   localparam int CTL_CASCADE   = 2;
   localparam int CTL_DIR_OWNER = 3;
   localparam int CTL_DIR_BIT   = 4;
   localparam byte_t CTL_RESET  = 8'h00;

   // Flag fields
   localparam int FLAG_SET    = 1;
   localparam int FLAG_MIRROR = 0;

   // Status fields
   localparam int ST_EMPTY      = 0;
   localparam int ST_FULL       = 1;
   localparam int ST_BOTH_EMPTY = 2;
   localparam int ST_BOTH_FULL  = 3;
   localparam int ST_FLAG_IN    = 4;
   localparam int ST_DIR_IN     = 5;
   localparam int ST_HOLD_FULL  = 6;

   typedef enum logic [1:0] {O_LOAD, O_SHOW, O_WAIT} out_state_e;

   typedef struct packed {
      logic [DEPTH-1:0][7:0] mem;
      logic [6:0]            wp;
      logic [6:0]            rp;
      logic [7:0]            cnt;
      byte_t                 hold;
      logic                  hold_full;
      logic                  ack_q;
      logic                  strb_q;
      out_state_e            ost;
      logic                  line_act;
      logic                  acc_o;
      byte_t                 ctl;
      logic                  flag;
      byte_t                 msg;
      byte_t                 rdata;
   } state_s;
endpackage : fifo_handshake_pkg

/* File: design/fifo_handshake_port.sv */
// Handshake port of a 128-byte FIFO buffer with its register port
`timescale 1ns/1ps
`default_nettype none
module fifo_handshake_port (
   // Clock and reset
   input  wire logic                       clk_in,
   input  wire logic                       rst_n_in,
   // Register port
   input  wire fifo_handshake_pkg::addr_t  reg_addr_in,
   input  wire fifo_handshake_pkg::byte_t  reg_wdata_in,
   input  wire logic                       reg_wr_in,
   input  wire logic                       reg_rd_in,
   output logic [7:0]                      reg_rdata_out,
   // Handshake data bus
   input  wire fifo_handshake_pkg::byte_t  hs_data_in,
   output logic [7:0]                      hs_data_out,
   output logic                            hs_data_oe_out,
   // Handshake lines
   output logic                            ready_or_valid_line_out,
   input  wire logic                       acknowledge_strobe_in,
   input  wire logic                       data_valid_strobe_in,
   input  wire logic                       ready_for_data_in,
   input  wire logic                       data_accepted_in,
   output logic                            data_accepted_out,
   // Direction pin
   input  wire logic                       dir_pin_in,
   output logic                            dir_pin_out,
   output logic                            dir_pin_oe_out,
   // Cascade lines
   output logic                            full_out,
   output logic                            empty_out,
   input  wire logic                       full_wired_in,
   input  wire logic                       empty_wired_in,
   output logic                            flag_output_line_out,
   input  wire logic                       flag_input_line_in
);
   import fifo_handshake_pkg::*;

   // Direction seen by this port: the owner takes its own control bit, the
   // follower takes the pin, which the owner drives with that same bit uninverted
   function automatic logic dir_of(input byte_t ctl, input logic pin);
      dir_of = ctl[CTL_DIR_OWNER] ? ctl[CTL_DIR_BIT] : pin;
   endfunction : dir_of

   // High on the sample at which a strobe goes from high to low
   function automatic logic fell_of(input logic prev, input logic now);
      fell_of = prev && !now;
   endfunction : fell_of

   // Strobe that hits one register index
   function automatic logic hits(input logic strobe, input addr_t addr, input addr_t idx);
      hits = strobe && (addr == idx);
   endfunction : hits

   // Count after one optional push and one optional pop in the same cycle
   function automatic logic [7:0] next_count(input logic [7:0] cnt, input logic push,
                                             input logic pop);
      next_count = cnt + (push ? CNT_ONE : ZERO_BYTE) - (pop ? CNT_ONE : ZERO_BYTE);
   endfunction : next_count

   // Status word; the combined bits follow the wired lines only in a cascade
   function automatic byte_t status_of(input logic loc_empty, input logic loc_full,
                                       input logic casc, input logic wired_empty,
                                       input logic wired_full, input logic flag_in,
                                       input logic dir, input logic held);
      byte_t st;
      st                = ZERO_BYTE;
      st[ST_EMPTY]      = loc_empty;
      st[ST_FULL]       = loc_full;
      st[ST_BOTH_EMPTY] = casc ? wired_empty : loc_empty;
      st[ST_BOTH_FULL]  = casc ? wired_full : loc_full;
      st[ST_FLAG_IN]    = flag_in;
      st[ST_DIR_IN]     = dir;
      st[ST_HOLD_FULL]  = held;
      status_of         = st;
   endfunction : status_of

   state_s s_r;
   state_s s_nxt;

   logic   dir_in;
   logic   three;
   logic   clr;
   logic   empty;
   logic   full;

   assign three = s_r.ctl[CTL_THREE];
   assign clr   = !s_r.ctl[CTL_CLEAR_N];
   assign empty = (s_r.cnt == ZERO_BYTE);
   assign full  = (s_r.cnt == DEPTH_CNT);
   // Owner uses its own bit; the follower sees the owner's bit on the pin unchanged
   assign dir_in = dir_of(s_r.ctl, dir_pin_in);

   always_comb begin
      logic       push;
      logic       pop;
      byte_t      wbyte;
      byte_t      rbyte;
      logic       ack_fall;
      logic       strb_fall;
      byte_t      status;
      logic       dir_nxt;
      s_nxt     = s_r;
      dir_nxt   = dir_in;
      push      = 1'b0;
      pop       = 1'b0;
      wbyte     = reg_wdata_in;
      rbyte     = s_r.mem[s_r.rp];
      ack_fall  = fell_of(s_r.ack_q, acknowledge_strobe_in);
      strb_fall = fell_of(s_r.strb_q, data_valid_strobe_in);
      status    = ZERO_BYTE;
      s_nxt.ack_q  = acknowledge_strobe_in;
      s_nxt.strb_q = data_valid_strobe_in;

      if (dir_in) begin
         // Input: peripheral fills the holding register, software drains
         if (s_r.hold_full && !full) begin
            push            = 1'b1;
            wbyte           = s_r.hold;
            s_nxt.hold_full = 1'b0;
         end
         if (hits(reg_rd_in, reg_addr_in, REG_DATA) && !empty) begin
            pop = 1'b1;
         end
         if (!three && s_r.line_act && ack_fall) begin
            s_nxt.hold      = hs_data_in;
            s_nxt.hold_full = 1'b1;
         end
         if (three && s_r.line_act && strb_fall) begin
            s_nxt.hold      = hs_data_in;
            s_nxt.hold_full = 1'b1;
            s_nxt.acc_o     = 1'b1;
         end
         if (three && data_valid_strobe_in) begin
            s_nxt.acc_o = 1'b0;
         end
         s_nxt.ost = O_LOAD;
      end else begin
         // Output: software fills, port drains toward the far side
         if (hits(reg_wr_in, reg_addr_in, REG_DATA) && !full) begin
            push = 1'b1;
         end
         s_nxt.acc_o = 1'b0;
         case (s_r.ost)
            O_LOAD: begin
               if (s_r.hold_full && (three ? (ready_for_data_in && !data_accepted_in)
                                           : acknowledge_strobe_in)) begin
                  s_nxt.ost = O_SHOW;
               end
            end
            O_SHOW: begin
               if (three ? data_accepted_in : ack_fall) begin
                  s_nxt.hold_full = 1'b0;
                  s_nxt.ost       = O_WAIT;
               end
            end
            O_WAIT: begin
               if (three ? !data_accepted_in : acknowledge_strobe_in) begin
                  s_nxt.ost = O_LOAD;
               end
            end
            default: begin
               s_nxt.ost = O_LOAD;
            end
         endcase
         // Refill as soon as the holding register is free, so the near buffer
         // empties into the far one before the far one counts down
         if (!s_nxt.hold_full && !empty) begin
            pop             = 1'b1;
            s_nxt.hold      = rbyte;
            s_nxt.hold_full = 1'b1;
         end
      end

      if (push) begin
         s_nxt.mem[s_r.wp] = wbyte;
         s_nxt.wp          = s_r.wp + PTR_ONE;
      end
      if (pop) begin
         s_nxt.rp = s_r.rp + PTR_ONE;
      end
      s_nxt.cnt = next_count(s_r.cnt, push, pop);

      if (dir_in) begin
         // Ready only with room, an empty holding register and an idle strobe
         s_nxt.line_act = !s_nxt.hold_full && (s_nxt.cnt != DEPTH_CNT)
                          && (three ? (data_valid_strobe_in && !s_nxt.acc_o)
                                    : acknowledge_strobe_in);
      end else begin
         // Valid stays inactive whenever nothing is held
         s_nxt.line_act = s_nxt.hold_full && (s_nxt.ost == O_SHOW);
      end

      // Register writes
      if (reg_wr_in) begin
         case (reg_addr_in)
            REG_CTL:  s_nxt.ctl = reg_wdata_in;
            REG_FLAG: s_nxt.flag = reg_wdata_in[FLAG_SET];
            REG_MSG: begin
               if (!s_r.ctl[CTL_CASCADE]) begin
                  s_nxt.msg = reg_wdata_in;
               end
            end
            default: begin
            end
         endcase
      end

      // A direction change written to the control register leaves the line inactive for the new sense, so a
      // ready still standing never shows up as a false valid
      dir_nxt = dir_of(s_nxt.ctl, dir_pin_in);
      if (dir_nxt != dir_in) begin
         s_nxt.line_act = 1'b0;
         s_nxt.ost      = O_LOAD;
      end

      status = status_of(empty, full, s_r.ctl[CTL_CASCADE], empty_wired_in, full_wired_in,
                         flag_input_line_in, dir_in, s_r.hold_full);

      if (reg_rd_in) begin
         case (reg_addr_in)
            REG_DATA:   s_nxt.rdata = (dir_in && !empty) ? rbyte : ZERO_BYTE;
            REG_CTL:    s_nxt.rdata = s_r.ctl;
            REG_FLAG: begin
               s_nxt.rdata              = ZERO_BYTE;
               s_nxt.rdata[FLAG_SET]    = s_r.flag;
               s_nxt.rdata[FLAG_MIRROR] = s_r.flag;
            end
            REG_STATUS: s_nxt.rdata = status;
            REG_COUNT:  s_nxt.rdata = s_r.cnt;
            REG_MSG:    s_nxt.rdata = s_r.ctl[CTL_CASCADE] ? ZERO_BYTE : s_r.msg;
            default:    s_nxt.rdata = ZERO_BYTE;
         endcase
      end

      // Clear empties everything but keeps the registers software owns
      if (clr) begin
         s_nxt.wp        = '0;
         s_nxt.rp        = '0;
         s_nxt.cnt       = ZERO_BYTE;
         s_nxt.hold_full = 1'b0;
         s_nxt.line_act  = 1'b0;
         s_nxt.acc_o     = 1'b0;
         s_nxt.ost       = O_LOAD;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Line polarity follows direction: active high ready, active low valid
   assign ready_or_valid_line_out = dir_in ? s_r.line_act : !s_r.line_act;
   assign reg_rdata_out           = s_r.rdata;
   assign hs_data_out             = s_r.hold;
   assign hs_data_oe_out          = !dir_in && !clr;
   assign data_accepted_out       = s_r.acc_o;
   assign dir_pin_out             = s_r.ctl[CTL_DIR_BIT];
   assign dir_pin_oe_out          = s_r.ctl[CTL_DIR_OWNER];
   assign full_out                = full;
   assign empty_out               = empty;
   assign flag_output_line_out    = s_r.flag;
endmodule : fifo_handshake_port
`default_nettype wire

/* File: bench/hs_port_asserts.sv */
// Concurrent checks on the handshake FIFO port
`timescale 1ns/1ps
`default_nettype none
module hs_port_asserts (
   // Clock, reset and register strobe
   input wire logic       clk_in,
   input wire logic       rst_n_in,
   input wire logic       reg_wr_in,
   // Handshake side
   input wire logic [7:0] hs_data_out,
   input wire logic       hs_data_oe_out,
   input wire logic       ready_or_valid_line_out,
   input wire logic       acknowledge_strobe_in,
   input wire logic       data_valid_strobe_in,
   input wire logic       data_accepted_out,
   input wire logic       flag_output_line_out,
   input wire logic       full_out
);
   default clocking @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   wire logic ln  = ready_or_valid_line_out;
   wire logic ack = acknowledge_strobe_in;
   wire logic oe  = hs_data_oe_out;
   wire logic acc = data_accepted_out;
   wire logic stb = data_valid_strobe_in;
   // Strobe seen high at one edge and low at the next
   sequence ack_fall;
      $fell(ack);
   endsequence
   full_hold_a: assert property (!oe && full_out |-> !ln)
      else $error("ready raised while buffer full");
   capture_a: assert property ((!oe && ln) ##0 ack_fall |=> !ln)
      else $error("ready kept high after a capture");
   ready_wait_a: assert property (!oe && $rose(ln) |-> $past(ack))
      else $error("ready rose while strobe low");
   show_ack_a: assert property (oe && $fell(ln) |-> $past(ack))
      else $error("valid shown while taker not ready");
   release_a: assert property ((oe && !ln) ##0 ack_fall |-> ##[1:2] ln)
      else $error("valid not released after byte taken");
   data_hold_a: assert property (oe && !ln && !$past(ln) |-> $stable(hs_data_out))
      else $error("output byte changed while valid");
   accept_drop_a: assert property (acc && stb |=> !acc)
      else $error("accepted held after strobe high");
   flag_wr_a: assert property ($changed(flag_output_line_out) |-> $past(reg_wr_in))
      else $error("flag line moved without a write");
endmodule : hs_port_asserts
bind fifo_handshake_port hs_port_asserts u_chk (.*);
`default_nettype wire

/* File: bench/hs_peer.sv */
// Peripheral model facing the handshake port: sends or takes bytes
`timescale 1ns/1ps
`default_nettype none
module hs_peer (
   // Control from the bench
   input  wire logic       clk_in,
   input  wire logic       send_in,
   input  wire logic       stall_in,
   // Handshake side
   input  wire logic       line_in,
   input  wire logic [7:0] data_in,
   output logic            ack_out,
   output logic [7:0]      data_out,
   output logic [7:0]      rx_out,
   output logic            got_out
);
   initial begin
      ack_out = 1'b1;
      data_out = 8'h00;
      rx_out = 8'h00;
      got_out = 1'b0;
   end
   // One line serves as strobe, ready and inverted accepted, like a lone acceptor
   always @(posedge clk_in) begin
      got_out <= 1'b0;
      if (!stall_in && ack_out && line_in == send_in) begin
         ack_out <= 1'b0;
         rx_out <= data_in;
         got_out <= !send_in;
      end else if (!ack_out && line_in != send_in) begin
         ack_out <= 1'b1;
         if (send_in)
            data_out <= data_out + 8'h01;
      end
   end
endmodule : hs_peer
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the handshake FIFO port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import fifo_handshake_pkg::*;
   logic  clk_in, rst_n_in, wr, rd, dpin, fin, send, stall;
   logic  ack, got, ln, full, empty, dpo, fl, hoe, doe;
   addr_t addr;
   byte_t wd, rdat, hin, hout, rx, nx;
   byte_t exp_q[$];
   int    n_mismatch, compares, cyc;
   fifo_handshake_port dut (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wdata_in(wd),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .hs_data_in(hin),
      .hs_data_out(hout), .hs_data_oe_out(hoe), .ready_or_valid_line_out(ln),
      .acknowledge_strobe_in(ack), .data_valid_strobe_in(ack), .ready_for_data_in(ack),
      .data_accepted_in(!ack), .data_accepted_out(), .dir_pin_in(dpin),
      .dir_pin_out(dpo), .dir_pin_oe_out(doe), .full_out(full), .empty_out(empty),
      .full_wired_in(full), .empty_wired_in(empty), .flag_output_line_out(fl),
      .flag_input_line_in(fin));
   hs_peer peer (.clk_in(clk_in), .send_in(send), .stall_in(stall), .line_in(ln),
      .data_in(hout), .ack_out(ack), .data_out(hin), .rx_out(rx), .got_out(got));
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   task automatic chk(input string what, input byte_t e, input byte_t v);
      compares++;
      if (v !== e) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, e, v);
      end
   endtask : chk
   task automatic wr_reg(input addr_t a, input byte_t v);
      @(posedge clk_in);
      addr <= a;
      wd <= v;
      wr <= 1'b1;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rchk(input addr_t a, input byte_t e);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_in);
      rd <= 1'b0;
      #1 chk($sformatf("register %0d", a), e, rdat);
   endtask : rchk
   task automatic wrap_up;
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : wrap_up
   // Bytes taken by the peer must arrive in write order
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         wrap_up();
      end
      if (got) begin
         chk("taken byte", exp_q[0], rx);
         exp_q.delete(0);
      end
   end
   initial begin
      {rst_n_in, wr, rd, dpin, fin, stall, send, addr, wd, nx} = '0;
      repeat (5) @(posedge clk_in);
      rst_n_in <= 1'b1;
      chk("idle line", 8'h01, {7'h00, ln});
      rchk(REG_STATUS, 8'h05);
      rchk(3'h6, 8'h00);
      fin <= 1'b1;
      wr_reg(REG_FLAG, 8'h02);
      rchk(REG_FLAG, 8'h03);
      chk("flag line", 8'h01, {7'h00, fl});
      rchk(REG_STATUS, 8'h15);
      wr_reg(REG_MSG, 8'h5a);
      rchk(REG_MSG, 8'h5a);
      wr_reg(REG_CTL, 8'h05);
      wr_reg(REG_MSG, 8'h33);
      rchk(REG_MSG, 8'h00);
      rchk(REG_STATUS, 8'h15);
      // Two-wire pass first, then three-wire; direction only flips while empty
      for (int t = 0; t < 2; t++) begin
         stall <= 1'b1;
         send <= 1'b0;
         wr_reg(REG_CTL, 8'h09 | {6'h00, t[0], 1'b0});
         stall <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            exp_q.push_back(8'ha0 + i[7:0]);
            wr_reg(REG_DATA, 8'ha0 + i[7:0]);
         end
         repeat (300) if (exp_q.size() != 0) @(posedge clk_in);
         repeat (4) @(posedge clk_in);
         chk("bytes left", 8'h00, byte_t'(exp_q.size()));
         chk("valid when empty", 8'h01, {7'h00, ln});
         chk("bus driven", 8'h01, {7'h00, hoe});
         stall <= 1'b1;
         wr_reg(REG_CTL, 8'h19 | {6'h00, t[0], 1'b0});
         send <= 1'b1;
         stall <= 1'b0;
         repeat (3000) if (!full) @(posedge clk_in);
         stall <= 1'b1;
         repeat (10) @(posedge clk_in);
         chk("ready when full", 8'h00, {7'h00, ln});
         chk("direction pin", 8'h01, {7'h00, dpo});
         chk("pin driven", 8'h01, {7'h00, doe});
         chk("bus released", 8'h00, {7'h00, hoe});
         rchk(REG_COUNT, 8'h80);
         for (int i = 0; i < 128; i++) begin
            rchk(REG_DATA, nx);
            nx++;
         end
         rchk(REG_COUNT, 8'h00);
      end
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
